// *** rtl/rest_sensor.sv ***
// sensor end: serial register slave, power level sequencer, capture and firmware control
//
// The plain strobed port was decided locally.
module rest_sensor #(
	parameter int RUN_TICK = rest_pkg::RUN_TICK_CYCLES,
	parameter int CRC_BUSY_CYCLES = 1000,
	parameter logic [7:0] L2_PERIOD = 8'h09,
	parameter logic [7:0] L2_IDLE = 8'hbc,
	parameter logic [7:0] L3_PERIOD = 8'h31
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	rest_link_if.device lnk,
	input wire logic motion_i,
	input wire logic hib_clk_i,
	input wire logic frame_start_i,
	input wire logic [15:0] agc_exposure_i,
	input wire logic [15:0] exposure_limit_i,
	input wire logic [15:0] auto_period_i,
	input wire logic [15:0] period_limit_i,
	output logic [1:0] mode_o,
	output logic rest_frame_o,
	output logic [15:0] exposure_o,
	output logic [15:0] frame_period_o,
	output logic [5:0] res_x_o,
	output logic [5:0] res_y_o,
	output logic nav_en_o,
	output logic capture_o,
	output logic download_start_o,
	output logic crc_busy_o
);
	initial begin
		if (RUN_TICK < 2 || RUN_TICK >= 2 ** 21 || CRC_BUSY_CYCLES < 1 ||
			CRC_BUSY_CYCLES >= 2 ** 21) begin
			$error("rest_sensor: unsupported parameter value");
		end
	end

	typedef struct packed {
		logic sclk_s1, sclk_s2, sclk_d;
		logic cs_s1, cs_s2;
		logic mosi_s1, mosi_s2;
		logic hib_s1, hib_s2, hib_d;
		logic [4:0] bitcnt;
		logic [15:0] shreg;
		logic [7:0] tx;
		logic [7:0] cfg, run_idle, l1_per, l1_idle, cap, res_x, res_y;
		rest_pkg::mode_e mode;
		logic [20:0] tick;
		logic [7:0] run_cnt;
		logic [7:0] hcnt;
		logic [13:0] fcnt;
		logic frame;
		logic cap_pend, cap_lost, fw_loaded, crc_busy;
		logic [20:0] crc_cnt;
		logic capture, dl_start;
		logic [15:0] exposure, period;
	} state_s;

	state_s s_r, s_nxt;

	function automatic logic [7:0] reg_read(input state_s s, input logic [6:0] a);
		case (a)
			rest_pkg::REG_MODE_CONFIG: reg_read = s.cfg;
			rest_pkg::REG_CAPTURE: reg_read = s.cap;
			rest_pkg::REG_RUN_IDLE: reg_read = s.run_idle;
			rest_pkg::REG_L1_PERIOD: reg_read = s.l1_per;
			rest_pkg::REG_L1_IDLE: reg_read = s.l1_idle;
			rest_pkg::REG_RES_X: reg_read = s.res_x;
			rest_pkg::REG_RES_Y: reg_read = s.res_y;
			rest_pkg::REG_STATUS: reg_read = {3'h0, !s.cap_lost && !s.crc_busy,
				s.crc_busy, s.fw_loaded, s.mode};
			default: reg_read = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] level_period(input state_s s);
		case (s.mode)
			rest_pkg::MODE_L1: level_period = s.l1_per;
			rest_pkg::MODE_L2: level_period = L2_PERIOD;
			default: level_period = L3_PERIOD;
		endcase
	endfunction

	function automatic logic [13:0] level_idle(input state_s s);
		case (s.mode)
			rest_pkg::MODE_L1: level_idle = 14'(s.l1_idle) * 14'(rest_pkg::L1_IDLE_STEP);
			default: level_idle = 14'(L2_IDLE) * 14'(rest_pkg::L2_IDLE_STEP);
		endcase
	endfunction

	always_comb begin
		logic rise;
		logic fall;
		logic hib_tick;
		logic [15:0] sh;
		logic [1:0] force_sel;
		rest_pkg::mode_e forced;
		rise = 1'b0;
		fall = 1'b0;
		hib_tick = 1'b0;
		sh = 16'h0000;
		force_sel = 2'h0;
		forced = rest_pkg::MODE_RUN;
		s_nxt = s_r;
		s_nxt.sclk_s1 = lnk.sclk;
		s_nxt.sclk_s2 = s_r.sclk_s1;
		s_nxt.sclk_d = s_r.sclk_s2;
		s_nxt.cs_s1 = lnk.cs_b;
		s_nxt.cs_s2 = s_r.cs_s1;
		s_nxt.mosi_s1 = lnk.mosi;
		s_nxt.mosi_s2 = s_r.mosi_s1;
		s_nxt.hib_s1 = hib_clk_i;
		s_nxt.hib_s2 = s_r.hib_s1;
		s_nxt.hib_d = s_r.hib_s2;
		s_nxt.frame = 1'b0;
		s_nxt.capture = 1'b0;
		s_nxt.dl_start = 1'b0;
		rise = s_r.sclk_s2 && !s_r.sclk_d;
		fall = !s_r.sclk_s2 && s_r.sclk_d;
		hib_tick = s_r.hib_s2 && !s_r.hib_d;
		sh = {s_r.shreg[14:0], s_r.mosi_s2};

		// serial port is ignored while the crc check runs
		if (s_r.cs_s2 || s_r.crc_busy) begin
			s_nxt.bitcnt = 5'h00;
		end else if (rise) begin
			s_nxt.shreg = sh;
			s_nxt.bitcnt = s_r.bitcnt + 5'h01;
			if (s_r.bitcnt == 5'(rest_pkg::FRAME_BITS / 2 - 1)) begin
				s_nxt.tx = sh[rest_pkg::WRITE_FLAG_BIT] ? 8'h00 : reg_read(s_r, sh[6:0]);
			end
			if (s_r.bitcnt == 5'(rest_pkg::FRAME_BITS - 1) &&
				sh[8 + rest_pkg::WRITE_FLAG_BIT]) begin
				case (sh[14:8])
					rest_pkg::REG_MODE_CONFIG: s_nxt.cfg = sh[7:0] & rest_pkg::CFG_WRITE_MASK;
					rest_pkg::REG_RUN_IDLE: s_nxt.run_idle = sh[7:0];
					rest_pkg::REG_L1_PERIOD: s_nxt.l1_per = sh[7:0];
					rest_pkg::REG_L1_IDLE: s_nxt.l1_idle = sh[7:0];
					rest_pkg::REG_RES_X: s_nxt.res_x = sh[7:0];
					rest_pkg::REG_RES_Y: s_nxt.res_y = sh[7:0];
					rest_pkg::REG_CAPTURE: begin
						s_nxt.cap = sh[7:0];
						s_nxt.cap_pend = 1'b1;
					end
					rest_pkg::REG_FW_START: begin
						if (sh[7:0] == rest_pkg::CRC_TEST_CODE) begin
							if (s_r.fw_loaded) begin
								s_nxt.crc_busy = 1'b1;
								s_nxt.crc_cnt = 21'h000000;
							end
						end else begin
							s_nxt.dl_start = 1'b1;
							s_nxt.fw_loaded = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end else if (fall && s_r.bitcnt > 5'(rest_pkg::FRAME_BITS / 2)) begin
			s_nxt.tx = {s_r.tx[6:0], 1'b0};
		end

		if (s_r.crc_busy) begin
			s_nxt.crc_cnt = s_r.crc_cnt + 21'h000001;
			if (s_r.crc_cnt == 21'(CRC_BUSY_CYCLES - 1)) begin
				s_nxt.crc_busy = 1'b0;
			end
		end

		// capture overwrites firmware; only a reset clears the loss
		if (s_r.cap_pend && frame_start_i) begin
			s_nxt.cap_pend = 1'b0;
			s_nxt.capture = 1'b1;
			s_nxt.cap_lost = 1'b1;
			s_nxt.fw_loaded = 1'b0;
		end

		force_sel = s_r.cfg[rest_pkg::CFG_FORCE_HI:rest_pkg::CFG_FORCE_LO];
		case (force_sel)
			2'h1: forced = rest_pkg::MODE_L1;
			2'h2: forced = rest_pkg::MODE_L2;
			default: forced = rest_pkg::MODE_L3;
		endcase

		if (force_sel != 2'h0 && s_r.mode != forced) begin
			s_nxt.mode = forced;
			s_nxt.hcnt = 8'h00;
			s_nxt.fcnt = 14'h0000;
		end else if (s_r.mode == rest_pkg::MODE_RUN) begin
			if (motion_i || !s_r.cfg[rest_pkg::CFG_REST_EN]) begin
				s_nxt.tick = 21'h000000;
				s_nxt.run_cnt = 8'h00;
			end else if (s_r.run_cnt >= s_r.run_idle) begin
				s_nxt.mode = rest_pkg::MODE_L1;
				s_nxt.hcnt = 8'h00;
				s_nxt.fcnt = 14'h0000;
				s_nxt.tick = 21'h000000;
				s_nxt.run_cnt = 8'h00;
			end else if (s_r.tick == 21'(RUN_TICK - 1)) begin
				s_nxt.tick = 21'h000000;
				s_nxt.run_cnt = s_r.run_cnt + 8'h01;
			end else begin
				s_nxt.tick = s_r.tick + 21'h000001;
			end
		end else if (force_sel == 2'h0 && (motion_i || !s_r.cfg[rest_pkg::CFG_REST_EN])) begin
			s_nxt.mode = rest_pkg::MODE_RUN;
			s_nxt.tick = 21'h000000;
			s_nxt.run_cnt = 8'h00;
		end else if (hib_tick) begin
			if (s_r.hcnt >= level_period(s_r)) begin
				s_nxt.hcnt = 8'h00;
				s_nxt.frame = 1'b1;
				s_nxt.fcnt = s_r.fcnt + 14'h0001;
				if (force_sel == 2'h0 && s_r.mode != rest_pkg::MODE_L3 &&
					s_r.fcnt + 14'h0001 >= level_idle(s_r)) begin
					s_nxt.mode = (s_r.mode == rest_pkg::MODE_L1) ? rest_pkg::MODE_L2 :
						rest_pkg::MODE_L3;
					s_nxt.fcnt = 14'h0000;
				end
			end else begin
				s_nxt.hcnt = s_r.hcnt + 8'h01;
			end
		end

		s_nxt.exposure = s_r.cfg[rest_pkg::CFG_AUTO_GAIN_OFF] ? exposure_limit_i :
			agc_exposure_i;
		s_nxt.period = s_r.cfg[rest_pkg::CFG_FIXED_FRAME_RATE] ? period_limit_i :
			auto_period_i;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.sclk_s1 <= 1'b1;
			s_r.sclk_s2 <= 1'b1;
			s_r.sclk_d <= 1'b1;
			s_r.cs_s1 <= 1'b1;
			s_r.cs_s2 <= 1'b1;
			s_r.cfg <= rest_pkg::RST_MODE_CONFIG;
			s_r.run_idle <= rest_pkg::RST_RUN_IDLE;
			s_r.l1_per <= rest_pkg::RST_L1_PERIOD;
			s_r.l1_idle <= rest_pkg::RST_L1_IDLE;
			s_r.res_x <= rest_pkg::RST_RES;
			s_r.res_y <= rest_pkg::RST_RES;
			s_r.mode <= rest_pkg::MODE_RUN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.miso = s_r.tx[7];
	assign mode_o = s_r.mode;
	assign rest_frame_o = s_r.frame;
	assign exposure_o = s_r.exposure;
	assign frame_period_o = s_r.period;
	assign res_x_o = s_r.res_x[5:0];
	assign res_y_o = s_r.cfg[rest_pkg::CFG_PER_AXIS] ? s_r.res_y[5:0] : s_r.res_x[5:0];
	assign nav_en_o = !s_r.cap_lost && !s_r.crc_busy;
	assign capture_o = s_r.capture;
	assign download_start_o = s_r.dl_start;
	assign crc_busy_o = s_r.crc_busy;
endmodule

// *** rtl/rest_pkg.sv ***
// shared constants for the rest mode control link and registers
package rest_pkg;
	localparam logic [6:0] REG_MODE_CONFIG = 7'h10;
	localparam logic [6:0] REG_CAPTURE = 7'h12;
	localparam logic [6:0] REG_FW_START = 7'h13;
	localparam logic [6:0] REG_RUN_IDLE = 7'h14;
	localparam logic [6:0] REG_L1_PERIOD = 7'h15;
	localparam logic [6:0] REG_L1_IDLE = 7'h16;
	localparam logic [6:0] REG_RES_X = 7'h0f;
	localparam logic [6:0] REG_RES_Y = 7'h2f;
	localparam logic [6:0] REG_STATUS = 7'h30;
	localparam logic [7:0] RST_MODE_CONFIG = 8'h00;
	localparam logic [7:0] RST_RUN_IDLE = 8'h32;
	localparam logic [7:0] RST_L1_PERIOD = 8'h01;
	localparam logic [7:0] RST_L1_IDLE = 8'h1f;
	localparam logic [7:0] RST_RES = 8'h12;
	localparam int CFG_FORCE_HI = 7;
	localparam int CFG_FORCE_LO = 6;
	localparam int CFG_REST_EN = 5;
	localparam int CFG_AUTO_GAIN_OFF = 4;
	localparam int CFG_FIXED_FRAME_RATE = 3;
	localparam int CFG_PER_AXIS = 2;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hfc;
	localparam logic [7:0] CRC_TEST_CODE = 8'h15;
	localparam int WRITE_FLAG_BIT = 7;
	localparam int FRAME_BITS = 16;
	localparam int L1_IDLE_STEP = 16;
	localparam int L2_IDLE_STEP = 32;
	localparam int CLK_HZ = 125000000;
	localparam int RUN_TICK_MS = 10;
	localparam int RUN_TICK_CYCLES = CLK_HZ / 1000 * RUN_TICK_MS;
	localparam int CRC_WAIT_MS = 10;
	localparam int CRC_WAIT_CYCLES = CLK_HZ / 1000 * CRC_WAIT_MS;
	localparam logic [1:0] HOST_ADDR = 2'h0;
	localparam logic [1:0] HOST_DATA = 2'h1;
	localparam logic [1:0] HOST_CTRL = 2'h2;
	localparam logic [1:0] HOST_STATUS = 2'h3;
	typedef enum logic [1:0] {MODE_RUN, MODE_L1, MODE_L2, MODE_L3} mode_e;
endpackage

// *** rtl/rest_link_if.sv ***
// four-wire serial link between controller and sensor
interface rest_link_if;
	logic sclk;
	logic cs_b;
	logic mosi;
	logic miso;
	modport device(input sclk, input cs_b, input mosi, output miso);
	modport host(output sclk, output cs_b, output mosi, input miso);
endinterface

// *** rtl/rest_host.sv ***
// controller end: runs serial register transfers ordered through a small command port
module rest_host #(
	parameter int HALF_CYCLES = 8,
	parameter int CRC_WAIT = rest_pkg::CRC_WAIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	rest_link_if.host lnk,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o
);
	initial begin
		if (HALF_CYCLES < 4 || HALF_CYCLES > 255 || CRC_WAIT < 1 || CRC_WAIT >= 2 ** 24) begin
			$error("rest_host: unsupported parameter value");
		end
	end

	typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_END, ST_CRC} host_e;
	typedef struct packed {
		host_e st;
		logic [6:0] addr;
		logic [7:0] data;
		logic is_read;
		logic [15:0] sh;
		logic [7:0] rx;
		logic [4:0] bitcnt;
		logic [23:0] cnt;
		logic sclk, cs_b, mosi;
		logic miso_s1, miso_s2;
		logic reset_needed;
		logic [7:0] rdata;
	} host_s;

	host_s s_r, s_nxt;

	always_comb begin
		logic busy;
		busy = s_r.st != ST_IDLE;
		s_nxt = s_r;
		s_nxt.miso_s1 = lnk.miso;
		s_nxt.miso_s2 = s_r.miso_s1;
		s_nxt.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				rest_pkg::HOST_ADDR: s_nxt.rdata = {1'b0, s_r.addr};
				rest_pkg::HOST_DATA: s_nxt.rdata = s_r.data;
				rest_pkg::HOST_STATUS: s_nxt.rdata = {5'h00, s_r.reset_needed,
					s_r.st == ST_CRC, busy};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		if (wr_i && !busy) begin
			case (addr_i)
				rest_pkg::HOST_ADDR: s_nxt.addr = wdata_i[6:0];
				rest_pkg::HOST_DATA: s_nxt.data = wdata_i;
				rest_pkg::HOST_CTRL: begin
					if (wdata_i[0] || wdata_i[1]) begin
						s_nxt.is_read = !wdata_i[0];
						s_nxt.sh = {wdata_i[0], s_r.addr, s_r.data};
						s_nxt.mosi = wdata_i[0];
						s_nxt.cs_b = 1'b0;
						s_nxt.sclk = 1'b0;
						s_nxt.bitcnt = 5'h00;
						s_nxt.cnt = 24'h000000;
						s_nxt.st = ST_LOW;
					end
				end
				default: begin
				end
			endcase
		end
		case (s_r.st)
			ST_IDLE: begin
			end
			ST_LOW: begin
				s_nxt.cnt = s_r.cnt + 24'h000001;
				if (s_r.cnt == 24'(HALF_CYCLES - 1)) begin
					s_nxt.cnt = 24'h000000;
					s_nxt.sclk = 1'b1;
					s_nxt.st = ST_HIGH;
				end
			end
			ST_HIGH: begin
				s_nxt.cnt = s_r.cnt + 24'h000001;
				if (s_r.cnt == 24'(HALF_CYCLES - 1)) begin
					s_nxt.cnt = 24'h000000;
					if (s_r.bitcnt >= 5'(rest_pkg::FRAME_BITS / 2)) begin
						s_nxt.rx = {s_r.rx[6:0], s_r.miso_s2};
					end
					s_nxt.bitcnt = s_r.bitcnt + 5'h01;
					if (s_r.bitcnt == 5'(rest_pkg::FRAME_BITS - 1)) begin
						s_nxt.cs_b = 1'b1;
						s_nxt.st = ST_END;
					end else begin
						s_nxt.sh = {s_r.sh[14:0], 1'b0};
						s_nxt.mosi = s_r.sh[14];
						s_nxt.sclk = 1'b0;
						s_nxt.st = ST_LOW;
					end
				end
			end
			ST_END: begin
				s_nxt.cnt = s_r.cnt + 24'h000001;
				s_nxt.mosi = 1'b0;
				if (s_r.cnt == 24'(HALF_CYCLES - 1)) begin
					s_nxt.cnt = 24'h000000;
					s_nxt.st = ST_IDLE;
					if (s_r.is_read) begin
						s_nxt.data = s_r.rx;
					end else if (s_r.addr == rest_pkg::REG_CAPTURE) begin
						s_nxt.reset_needed = 1'b1;
					end else if (s_r.addr == rest_pkg::REG_FW_START &&
						s_r.data == rest_pkg::CRC_TEST_CODE) begin
						s_nxt.st = ST_CRC;
					end
				end
			end
			ST_CRC: begin
				s_nxt.cnt = s_r.cnt + 24'h000001;
				if (s_r.cnt == 24'(CRC_WAIT - 1)) begin
					s_nxt.cnt = 24'h000000;
					s_nxt.st = ST_IDLE;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.sclk <= 1'b1;
			s_r.cs_b <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.sclk = s_r.sclk;
	assign lnk.cs_b = s_r.cs_b;
	assign lnk.mosi = s_r.mosi;
	assign rdata_o = s_r.rdata;
endmodule

// *** verification/rest_checker.sv ***
// link and sensor output assertions for the rest mode pair
module rest_checker #(
	parameter int CRC_BUSY = 10
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic [1:0] mode_o,
	input wire logic rest_frame_o,
	input wire logic nav_en_o,
	input wire logic capture_o,
	input wire logic download_start_o,
	input wire logic crc_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	property p_idle_sclk; cs_b |-> sclk; endproperty
	a_idle_sclk: assert property (p_idle_sclk) else $error("serial clock low while deselected");
	property p_select_low; $fell(cs_b) |-> !sclk; endproperty
	a_select_low: assert property (p_select_low) else $error("frame opened with clock high");
	property p_crc_nav; crc_busy_o |-> !nav_en_o; endproperty
	a_crc_nav: assert property (p_crc_nav) else $error("navigation on during check");
	property p_crc_len; $rose(crc_busy_o) |-> crc_busy_o[*8] and ##CRC_BUSY !crc_busy_o; endproperty
	a_crc_len: assert property (p_crc_len) else $error("check busy length wrong");
	property p_dl_pulse; download_start_o |=> !download_start_o; endproperty
	a_dl_pulse: assert property (p_dl_pulse) else $error("download start too long");
	property p_cap_nav; capture_o |=> !nav_en_o; endproperty
	a_cap_nav: assert property (p_cap_nav) else $error("navigation on after capture");
	property p_nav_hold; !nav_en_o && !crc_busy_o |=> !nav_en_o; endproperty
	a_nav_hold: assert property (p_nav_hold) else $error("navigation back without reset");
	property p_frame_mode;
		rest_frame_o |-> mode_o != rest_pkg::MODE_RUN || $past(mode_o) != rest_pkg::MODE_RUN;
	endproperty
	a_frame_mode: assert property (p_frame_mode) else $error("rest frame in run mode");
	property p_frame_gap; rest_frame_o |=> !rest_frame_o[*8]; endproperty
	a_frame_gap: assert property (p_frame_gap) else $error("rest frames too close");
endmodule

// *** verification/testbench.sv ***
// self-checking bench: host command port drives the sensor over the serial link
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic hib_clk = 1'b0;
	logic motion = 1'b0;
	logic fstart = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, d;
	logic [1:0] mode;
	logic rest_frame, nav_en, capture, dl_start, crc_busy;
	logic [15:0] expo, fperiod;
	logic [15:0] agc_expo = 16'h1111;
	logic [15:0] expo_limit = 16'h2222;
	logic [15:0] auto_per = 16'h3333;
	logic [15:0] per_limit = 16'h4444;
	logic [5:0] res_x, res_y;
	int err_count = 0;
	int samples_checked = 0;
	int crc_seen = 0;
	int dl_seen = 0;
	int cap_seen = 0;
	int frames = 0;
	int n;
	logic [6:0] ra[10] = '{rest_pkg::REG_MODE_CONFIG, rest_pkg::REG_CAPTURE,
		rest_pkg::REG_FW_START, rest_pkg::REG_RUN_IDLE, rest_pkg::REG_L1_PERIOD,
		rest_pkg::REG_L1_IDLE, rest_pkg::REG_RES_X, rest_pkg::REG_RES_Y, rest_pkg::REG_STATUS, 7'h7f};
	logic [7:0] rv[10] = '{rest_pkg::RST_MODE_CONFIG, 8'h00, 8'h00, rest_pkg::RST_RUN_IDLE,
		rest_pkg::RST_L1_PERIOD, rest_pkg::RST_L1_IDLE, rest_pkg::RST_RES, rest_pkg::RST_RES,
		8'h10, 8'h00};
	rest_link_if lnk();
	always #4 clk_i = ~clk_i;
	always #130 hib_clk = ~hib_clk;
	rest_host #(.CRC_WAIT(50)) rest_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(lnk),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	rest_sensor #(.RUN_TICK(20), .CRC_BUSY_CYCLES(10), .L2_PERIOD(8'h00),
		.L2_IDLE(8'h01)) rest_sensor_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(lnk),
		.motion_i(motion), .hib_clk_i(hib_clk), .frame_start_i(fstart),
		.agc_exposure_i(agc_expo), .exposure_limit_i(expo_limit), .auto_period_i(auto_per),
		.period_limit_i(per_limit), .mode_o(mode), .rest_frame_o(rest_frame), .exposure_o(expo),
		.frame_period_o(fperiod), .res_x_o(res_x), .res_y_o(res_y), .nav_en_o(nav_en),
		.capture_o(capture), .download_start_o(dl_start), .crc_busy_o(crc_busy));
	rest_checker rest_checker_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.sclk(lnk.sclk), .cs_b(lnk.cs_b), .mode_o(mode), .rest_frame_o(rest_frame),
		.nav_en_o(nav_en), .capture_o(capture), .download_start_o(dl_start),
		.crc_busy_o(crc_busy));
	always @(posedge clk_i) begin
		if (crc_busy === 1'b1)
			crc_seen <= crc_seen + 1;
		if (dl_start === 1'b1)
			dl_seen <= dl_seen + 1;
		if (capture === 1'b1)
			cap_seen <= cap_seen + 1;
		if (rest_frame === 1'b1)
			frames <= frames + 1;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hwr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic hrd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic idle();
		logic [7:0] s;
		s = 8'h01;
		for (int i = 0; i < 500 && s[0] !== 1'b0; i++)
			hrd(rest_pkg::HOST_STATUS, s);
		chk("host idle", 16'h0, 16'(s[0]));
	endtask
	task automatic dwr(input logic [6:0] r, input logic [7:0] v);
		hwr(rest_pkg::HOST_ADDR, {1'b0, r});
		hwr(rest_pkg::HOST_DATA, v);
		hwr(rest_pkg::HOST_CTRL, 8'h01);
		idle();
	endtask
	task automatic drd(input logic [6:0] r, output logic [7:0] v);
		hwr(rest_pkg::HOST_ADDR, {1'b0, r});
		hwr(rest_pkg::HOST_CTRL, 8'h02);
		idle();
		hrd(rest_pkg::HOST_DATA, v);
	endtask
	task automatic wmode(input logic [1:0] m, output int c);
		c = 0;
		while (mode !== m && c < 4000) begin
			@(posedge clk_i);
			c++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#600000;
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			drd(ra[i], d);
			chk("reset value", 16'(rv[i]), 16'(d));
		end
		dwr(rest_pkg::REG_RES_X, 8'h05);
		dwr(rest_pkg::REG_RES_Y, 8'h20);
		chk("shared y res", 16'h5, 16'(res_y));
		dwr(rest_pkg::REG_MODE_CONFIG, 8'h04);
		chk("own y res", 16'h20, 16'(res_y));
		chk("own x res", 16'h5, 16'(res_x));
		chk("auto exposure", 16'h1111, expo);
		chk("auto period", 16'h3333, fperiod);
		dwr(rest_pkg::REG_MODE_CONFIG, 8'h1b);
		drd(rest_pkg::REG_MODE_CONFIG, d);
		chk("config readback", 16'h18, 16'(d));
		chk("fixed exposure", 16'h2222, expo);
		chk("fixed period", 16'h4444, fperiod);
		chk("rest disabled", 16'h0, 16'(mode));
		motion <= 1'b1;
		for (int f = 1; f < 4; f++) begin
			dwr(rest_pkg::REG_MODE_CONFIG, {f[1:0], 6'h20});
			chk("forced level", 16'(f), 16'(mode));
		end
		motion <= 1'b0;
		dwr(rest_pkg::REG_MODE_CONFIG, 8'h20);
		repeat (200) @(posedge clk_i);
		chk("released level 3", 16'h3, 16'(mode));
		motion <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("motion wakes", 16'h0, 16'(mode));
		dwr(rest_pkg::REG_L1_PERIOD, 8'h00);
		dwr(rest_pkg::REG_L1_IDLE, 8'h01);
		for (int f = 1; f < 3; f++) begin
			dwr(rest_pkg::REG_MODE_CONFIG, {f[1:0], 6'h20});
			motion <= 1'b0;
			dwr(rest_pkg::REG_MODE_CONFIG, 8'h20);
			chk("resume level", 16'(f), 16'(mode));
			wmode(f[1:0] + 2'h1, n);
			chk("step down", 16'(f + 1), 16'(mode));
			wmode(2'h3, n);
			chk("deepest level", 16'h3, 16'(mode));
			motion <= 1'b1;
			repeat (2) @(posedge clk_i);
			chk("back to run", 16'h0, 16'(mode));
		end
		dwr(rest_pkg::REG_L1_PERIOD, 8'h01);
		dwr(rest_pkg::REG_RUN_IDLE, 8'h02);
		motion <= 1'b0;
		repeat (30) @(posedge clk_i);
		motion <= 1'b1;
		@(posedge clk_i);
		motion <= 1'b0;
		wmode(2'h1, n);
		chk("idle restart", 16'h1, 16'(n >= 38 && n <= 44));
		n = frames;
		repeat (640) @(posedge clk_i);
		chk("level 1 frames", 16'h1, 16'(frames - n >= 9 && frames - n <= 11));
		motion <= 1'b1;
		dwr(rest_pkg::REG_FW_START, rest_pkg::CRC_TEST_CODE);
		chk("check before load", 16'h0, 16'(crc_seen));
		dwr(rest_pkg::REG_FW_START, 8'h01);
		chk("download pulse", 16'h1, 16'(dl_seen));
		drd(rest_pkg::REG_STATUS, d);
		chk("fault free before check", 16'h14, 16'(d));
		dwr(rest_pkg::REG_FW_START, rest_pkg::CRC_TEST_CODE);
		chk("check busy time", 16'ha, 16'(crc_seen));
		drd(rest_pkg::REG_STATUS, d);
		chk("status loaded", 16'h14, 16'(d));
		dwr(rest_pkg::REG_CAPTURE, 8'h01);
		chk("nav before frame", 16'h1, 16'(nav_en));
		@(posedge clk_i);
		fstart <= 1'b1;
		@(posedge clk_i);
		fstart <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("capture pulse", 16'h1, 16'(cap_seen));
		chk("nav stopped", 16'h0, 16'(nav_en));
		hrd(rest_pkg::HOST_STATUS, d);
		chk("reset needed", 16'h1, 16'(d[2]));
		drd(rest_pkg::REG_STATUS, d);
		chk("firmware lost", 16'h0, 16'(d));
		print_verdict();
	end
endmodule
